// ===== core/imp_regs.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - supply mask bit 7 blocks upper warning
// - supply mask bit 6 blocks sysvolt monitor
// - supply mask bit 5 blocks ramp done
// - supply mask bit 4 blocks regulator monitor
// - supply mask bit 2 blocks low comparator
// - supply mask bit 1 blocks over-temperature
// - supply mask bit 0 blocks charger wake
// - low input mask masks input events 7..0
// - low bits 2..0 also mask converter thresholds
// - high mask masks 15..8, bit 6 two-wire
// - high bits 2..0 mask enable port events
// - bits 6..4 block writes to targets 2..0
// - bit 3 selects full or partial down
// - targets follow register and enable ports
// - bit 7 enables buck soft start
// - key lock bit, cleared at power-up
// - bit 3 asserts reset before power-down
// - bit 2 enables limited blinking
// - bit 1 selects watchdog power-down behaviour
// - bit 0 declares charger port type
// - interrupt released only when events cleared or masked
module imp_regs (
    input wire logic sys_clk, // 125 MHz clock
    input wire logic rst, // synchronous reset, active high
    input wire logic clk_en, // freezes all state when low
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic [7:0] supply_event_in, // supply event pulses
    input wire logic [15:0] input_event_in, // input event pulses
    input wire logic domain_one_enable_port, // domain one enable port
    input wire logic main_enable_port, // main enable port
    input wire logic system_enable_port, // system enable port
    input wire logic powerup_seq, // power-up sequence running
    output logic interrupt_out_n, // interrupt, active low
    output imp_pkg::imp_domain_t domain_out, // targets and depth
    output imp_pkg::imp_options_t options_out, // system options
    output logic watchdog_suspend // watchdog held in power-down
);
    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] supply_mask_r; // supply event mask
    logic [7:0] in_mask_lo_r; // input event mask low
    logic [7:0] in_mask_hi_r; // input event mask high
    logic [7:0] pwr_dom_r; // power domain control
    logic [7:0] sys_opt_r; // system options
    logic [7:0] sup_ev_r; // latched supply events
    logic [15:0] in_ev_r; // latched input events
    logic [2:0] port_q_r; // previous port levels
    logic [7:0] rdata_nxt; // read mux

    ////////////////////////////////////////////////////////////////////////////////
    // decode
    wire wr_sup_mask = reg_wr && (reg_addr == imp_pkg::ADDR_SUPPLY_MASK);
    wire wr_lo_mask = reg_wr && (reg_addr == imp_pkg::ADDR_INPUT_MASK_LO);
    wire wr_hi_mask = reg_wr && (reg_addr == imp_pkg::ADDR_INPUT_MASK_HI);
    wire wr_pwr = reg_wr && (reg_addr == imp_pkg::ADDR_PWR_DOMAIN);
    wire wr_opt = reg_wr && (reg_addr == imp_pkg::ADDR_SYS_OPTIONS);
    wire wr_sup_ev = reg_wr && (reg_addr == imp_pkg::ADDR_SUPPLY_EVENT);
    wire wr_lo_ev = reg_wr && (reg_addr == imp_pkg::ADDR_INPUT_EVENT_LO);
    wire wr_hi_ev = reg_wr && (reg_addr == imp_pkg::ADDR_INPUT_EVENT_HI);

    ////////////////////////////////////////////////////////////////////////////////
    // event latches: new events win over the write-back clear
    wire [7:0] sup_clr = wr_sup_ev ? reg_wdata : 8'h00;
    wire [15:0] in_clr = {(wr_hi_ev ? reg_wdata : 8'h00), (wr_lo_ev ? reg_wdata : 8'h00)};
    wire [7:0] sup_ev_nxt = (sup_ev_r & ~sup_clr) | supply_event_in;
    wire [15:0] in_ev_nxt = (in_ev_r & ~in_clr) | input_event_in;

    // masking only gates the output; bit 3 has no rule but masks alike
    wire [7:0] sup_pend = sup_ev_r & ~supply_mask_r;
    // converter thresholds share bits 2..0 with input events 2..0
    wire [7:0] lo_pend = in_ev_r[7:0] & ~in_mask_lo_r;
    // two-wire address event shares bit 14, enable ports bits 10..8
    wire [7:0] hi_pend = in_ev_r[15:8] & ~in_mask_hi_r;
    // line stays low while any unmasked event remains uncleared
    wire irq_any = |{sup_pend, lo_pend, hi_pend};

    ////////////////////////////////////////////////////////////////////////////////
    // domain targets: write-masked register path plus port edges
    localparam int NT = imp_pkg::B_TGT_HI - imp_pkg::B_TGT_LO + 1;
    wire [2:0] ports = {domain_one_enable_port, main_enable_port, system_enable_port};
    wire [2:0] port_rise = ports & ~port_q_r;
    wire [2:0] port_fall = ~ports & port_q_r;
    wire [2:0] wmask = pwr_dom_r[imp_pkg::B_WMASK_HI:imp_pkg::B_WMASK_LO];
    logic [2:0] tgt_nxt; // next targets
    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++) begin : g_tgt
            // a port edge overrides a same-cycle write: the pin is the live request
            assign tgt_nxt[gi] = port_rise[gi] ? 1'b1 : port_fall[gi] ? 1'b0 :
                (wr_pwr && !wmask[gi]) ? reg_wdata[imp_pkg::B_TGT_LO + gi] :
                pwr_dom_r[imp_pkg::B_TGT_LO + gi];
        end
    endgenerate
    // fields above the targets written directly, bit 7 reserved
    wire [7:0] pwr_upper = wr_pwr ? (reg_wdata & imp_pkg::PWR_DOMAIN_RW) : pwr_dom_r;
    wire [7:0] pwr_nxt = {pwr_upper[7:imp_pkg::B_STANDBY], tgt_nxt};

    // options; key lock self-clears at power-up, hardware wins
    wire [7:0] opt_w = wr_opt ? (reg_wdata & imp_pkg::SYS_OPTIONS_RW) : sys_opt_r;
    wire [7:0] key_clr = {3'h0, powerup_seq, 4'h0};
    wire [7:0] opt_nxt = opt_w & ~key_clr;

    ////////////////////////////////////////////////////////////////////////////////
    // read mux, unmapped reads zero
    always_comb begin
        if (reg_addr == imp_pkg::ADDR_SUPPLY_MASK) begin
            rdata_nxt = supply_mask_r;
        end else if (reg_addr == imp_pkg::ADDR_INPUT_MASK_LO) begin
            rdata_nxt = in_mask_lo_r;
        end else if (reg_addr == imp_pkg::ADDR_INPUT_MASK_HI) begin
            rdata_nxt = in_mask_hi_r;
        end else if (reg_addr == imp_pkg::ADDR_PWR_DOMAIN) begin
            rdata_nxt = pwr_dom_r;
        end else if (reg_addr == imp_pkg::ADDR_SYS_OPTIONS) begin
            rdata_nxt = sys_opt_r;
        end else if (reg_addr == imp_pkg::ADDR_SUPPLY_EVENT) begin
            rdata_nxt = sup_ev_r;
        end else if (reg_addr == imp_pkg::ADDR_INPUT_EVENT_LO) begin
            rdata_nxt = in_ev_r[7:0];
        end else if (reg_addr == imp_pkg::ADDR_INPUT_EVENT_HI) begin
            rdata_nxt = in_ev_r[15:8];
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // masks and control
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            supply_mask_r <= imp_pkg::RST_MASK;
            in_mask_lo_r <= imp_pkg::RST_MASK;
            in_mask_hi_r <= imp_pkg::RST_MASK;
            pwr_dom_r <= imp_pkg::RST_CTRL;
            sys_opt_r <= imp_pkg::RST_CTRL;
        end else if (clk_en) begin
            if (wr_sup_mask) supply_mask_r <= reg_wdata;
            if (wr_lo_mask) in_mask_lo_r <= reg_wdata;
            if (wr_hi_mask) in_mask_hi_r <= reg_wdata;
            pwr_dom_r <= pwr_nxt;
            sys_opt_r <= opt_nxt;
        end
    end

    // events and port history; ports sampled low at reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sup_ev_r <= 8'h00;
            in_ev_r <= 16'h0000;
            port_q_r <= 3'h0;
        end else if (clk_en) begin
            sup_ev_r <= sup_ev_nxt;
            in_ev_r <= in_ev_nxt;
            port_q_r <= ports;
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            interrupt_out_n <= 1'b1;
            domain_out <= '0;
            options_out <= '0;
            watchdog_suspend <= 1'b0;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
            interrupt_out_n <= !irq_any;
            domain_out.standby_depth <= pwr_dom_r[imp_pkg::B_STANDBY];
            domain_out.domain_one_target <= pwr_dom_r[imp_pkg::B_TGT_HI];
            domain_out.main_target <= pwr_dom_r[imp_pkg::B_TGT_LO + 1];
            domain_out.system_target <= pwr_dom_r[imp_pkg::B_TGT_LO];
            options_out.switcher_soft_start <= sys_opt_r[imp_pkg::B_SOFT_START];
            options_out.power_key_lock <= sys_opt_r[imp_pkg::B_KEY_LOCK];
            options_out.reset_before_deep_sleep_state <= sys_opt_r[imp_pkg::B_RST_BEFORE_PD];
            options_out.limited_blink_enable <= sys_opt_r[imp_pkg::B_BLINK];
            options_out.watchdog_deep_sleep_state_hold <= sys_opt_r[imp_pkg::B_WDOG_PD];
            options_out.charger_port_type <= sys_opt_r[imp_pkg::B_CHG_TYPE];
            watchdog_suspend <= sys_opt_r[imp_pkg::B_WDOG_PD];
        end
    end
endmodule

// ===== shared/imp_pkg.sv
package imp_pkg;
    // register offsets
    localparam logic [7:0] ADDR_SUPPLY_MASK = 8'h0b;
    localparam logic [7:0] ADDR_INPUT_MASK_LO = 8'h0c;
    localparam logic [7:0] ADDR_INPUT_MASK_HI = 8'h0d;
    localparam logic [7:0] ADDR_PWR_DOMAIN = 8'h0e;
    localparam logic [7:0] ADDR_SYS_OPTIONS = 8'h0f;
    // event registers, written back to clear
    localparam logic [7:0] ADDR_SUPPLY_EVENT = 8'h07;
    localparam logic [7:0] ADDR_INPUT_EVENT_LO = 8'h08;
    localparam logic [7:0] ADDR_INPUT_EVENT_HI = 8'h09;
    // reset values
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    // supply mask bit positions
    localparam int B_UPPER_WARN = 7;
    localparam int B_SYSVOLT = 6;
    localparam int B_RAMP_DONE = 5;
    localparam int B_REG_MON = 4;
    localparam int B_LIN_LIMIT = 3;
    localparam int B_LOW_COMP = 2;
    localparam int B_TEMP = 1;
    localparam int B_CHARGER_WAKE_PORT = 0;
    // power domain control fields
    localparam int B_WMASK_HI = 6;
    localparam int B_WMASK_LO = 4;
    localparam int B_STANDBY = 3;
    localparam int B_TGT_HI = 2;
    localparam int B_TGT_LO = 0;
    localparam logic [7:0] PWR_DOMAIN_RW = 8'h7f;
    // system options fields
    localparam int B_SOFT_START = 7;
    localparam int B_KEY_LOCK = 4;
    localparam int B_RST_BEFORE_PD = 3;
    localparam int B_BLINK = 2;
    localparam int B_WDOG_PD = 1;
    localparam int B_CHG_TYPE = 0;
    localparam logic [7:0] SYS_OPTIONS_RW = 8'h9f;
    // soft start lengthening of buck start-up
    localparam int SOFT_START_MAX_MS = 3;

    // options bits handed to the power logic
    typedef struct packed {
        logic switcher_soft_start;
        logic power_key_lock;
        logic reset_before_deep_sleep_state;
        logic limited_blink_enable;
        logic watchdog_deep_sleep_state_hold;
        logic charger_port_type;
    } imp_options_t;

    // domain targets and depth
    typedef struct packed {
        logic standby_depth;
        logic domain_one_target;
        logic main_target;
        logic system_target;
    } imp_domain_t;
endpackage

// ===== verif/imp_host.sv
`timescale 1ns/10ps
module imp_host (
    input wire logic sys_clk, // clock
    input wire logic [7:0] reg_rdata, // read data
    output logic [7:0] reg_addr, // address
    output logic [7:0] reg_wdata, // write data
    output logic reg_wr, // write strobe
    output logic reg_rd // read strobe
);
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one-cycle write; data inverted after so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // one-cycle read; data taken at the following edge only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
endmodule

// ===== verif/imp_regs_chk.sv
`timescale 1ns/10ps
module imp_regs_chk (
    input wire logic sys_clk, // clock
    input wire logic rst, // sync reset
    input wire logic [7:0] reg_addr, // address
    input wire logic reg_wr, // write strobe
    input wire logic [7:0] supply_event_in, // supply events
    input wire logic [15:0] input_event_in, // input events
    input wire logic domain_one_enable_port, // domain one port
    input wire logic system_enable_port, // system port
    input wire logic powerup_seq, // power-up running
    input wire logic interrupt_out_n, // interrupt, active low
    input wire imp_pkg::imp_domain_t domain_out, // targets
    input wire imp_pkg::imp_options_t options_out, // options
    input wire logic watchdog_suspend // watchdog hold
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // outputs move two edges after the write that caused them
    AST_DOM_ONE_RISE: assert property ($rose(domain_one_enable_port) |-> ##[1:3]
        domain_out.domain_one_target) else $error("domain one target not set by port");
    AST_SYS_FALL: assert property ($fell(system_enable_port) |-> ##[1:3]
        !domain_out.system_target) else $error("system target not cleared by port");
    AST_DEPTH_WR: assert property (!$stable(domain_out.standby_depth) |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == imp_pkg::ADDR_PWR_DOMAIN)
        else $error("standby depth moved without a write");
    AST_SOFT_WR: assert property (!$stable(options_out.switcher_soft_start) |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == imp_pkg::ADDR_SYS_OPTIONS)
        else $error("soft start moved without a write");
    AST_RSTPD_WR: assert property (!$stable(options_out.reset_before_deep_sleep_state) |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == imp_pkg::ADDR_SYS_OPTIONS)
        else $error("reset mode moved without a write");
    AST_KEY_CLR: assert property (powerup_seq |-> ##2 !options_out.power_key_lock)
        else $error("key lock survived power-up");
    AST_WDOG: assert property ($changed(watchdog_suspend) |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == imp_pkg::ADDR_SYS_OPTIONS)
        else $error("watchdog suspend moved without a write");
    AST_IRQ_REL: assert property ($rose(interrupt_out_n) |-> $past(reg_wr, 2))
        else $error("interrupt released without a host write");
    AST_IRQ_SET: assert property ($fell(interrupt_out_n) |-> $past(reg_wr, 2) ||
        $past(supply_event_in, 2) != 8'h00 || $past(input_event_in, 2) != 16'h0000)
        else $error("interrupt asserted without a cause");
endmodule
bind imp_regs imp_regs_chk u_chk (.sys_clk, .rst, .reg_addr, .reg_wr, .supply_event_in,
    .input_event_in, .domain_one_enable_port, .system_enable_port, .powerup_seq,
    .interrupt_out_n, .domain_out, .options_out, .watchdog_suspend);

// ===== verif/tb_irq_mask_and_power_control_regs.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_irq_mask_and_power_control_regs;
    logic sys_clk = 1'b0; // 125 MHz
    logic rst = 1'b1; // sync reset
    logic [7:0] reg_addr, reg_wdata, reg_rdata; // register bus
    logic reg_wr, reg_rd, irq_n, wsus; // strobes and flags
    logic [23:0] ev = 24'h00_0000; // input events above supply events
    logic [2:0] port = 3'h0; // domain one, main, system
    logic pup = 1'b0; // power-up sequence
    imp_pkg::imp_domain_t dom; // targets seen
    imp_pkg::imp_options_t opt; // options seen
    int errors = 0;
    int checked = 0;
    // clock
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    imp_host u_host (.sys_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    imp_regs u_dut (.sys_clk, .rst, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .supply_event_in(ev[7:0]), .input_event_in(ev[23:8]),
        .domain_one_enable_port(port[2]), .main_enable_port(port[1]),
        .system_enable_port(port[0]), .powerup_seq(pup), .interrupt_out_n(irq_n),
        .domain_out(dom), .options_out(opt), .watchdog_suspend(wsus));
    ////////////////////////////////////////////////////////////////////////////////
    // let the edge's updates land before looking
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // event, mask and mapped range all read zero after reset, 0x0a and 0x10 unmapped
    task automatic t_reset();
        logic [7:0] d;
        for (int a = 7; a <= 16; a++) begin
            u_host.rd(8'(a), d);
            `CHK("reset value", 8'h00, d)
        end
        `CHK("irq idle", 1'b1, irq_n)
        `CHK("targets idle", 4'h0, dom)
        `CHK("options idle", 6'h00, opt)
        `CHK("wdog idle", 1'b0, wsus)
    endtask
    // every event bit: masked stays quiet yet latches, unmasked fires
    task automatic t_masks();
        logic [7:0] d, m, e;
        for (int i = 0; i < 24; i++) begin
            m = (i < 8) ? 8'h0b : (i < 16) ? 8'h0c : 8'h0d;
            e = m - 8'h04;
            u_host.wr(m, 8'h01 << (i % 8));
            @(posedge sys_clk);
            ev <= 24'h00_0001 << i;
            @(posedge sys_clk);
            ev <= 24'h00_0000;
            tick(3);
            `CHK("masked", 1'b1, irq_n)
            u_host.rd(e, d);
            `CHK("latched", 8'h01 << (i % 8), d)
            u_host.wr(m, 8'h00);
            tick(2);
            `CHK("unmasked", 1'b0, irq_n)
            u_host.wr(e, d);
            tick(2);
            `CHK("released", 1'b1, irq_n)
        end
    endtask
    // write masking, depth and port control of the targets
    task automatic t_domain();
        logic [7:0] d;
        u_host.wr(imp_pkg::ADDR_PWR_DOMAIN, 8'h07);
        tick(2);
        `CHK("targets", 4'h7, dom)
        u_host.wr(imp_pkg::ADDR_PWR_DOMAIN, 8'h77);
        u_host.wr(imp_pkg::ADDR_PWR_DOMAIN, 8'hf0);
        u_host.rd(imp_pkg::ADDR_PWR_DOMAIN, d);
        `CHK("write masked", 8'h77, d)
        u_host.wr(imp_pkg::ADDR_PWR_DOMAIN, 8'h0f);
        u_host.wr(imp_pkg::ADDR_PWR_DOMAIN, 8'h08);
        tick(2);
        `CHK("depth", 4'h8, dom)
        for (int p = 0; p < 3; p++) begin
            @(posedge sys_clk);
            port <= 3'(1 << p);
            tick(3);
            `CHK("port set", 4'h8 | 4'(1 << p), dom)
            @(posedge sys_clk);
            port <= 3'h0;
            tick(3);
            `CHK("port clear", 4'h8, dom)
        end
    endtask
    // options, reserved bits, power-up clearing of key lock
    task automatic t_options();
        logic [7:0] d;
        u_host.wr(imp_pkg::ADDR_SYS_OPTIONS, 8'hff);
        u_host.rd(imp_pkg::ADDR_SYS_OPTIONS, d);
        `CHK("options read", 8'h9f, d)
        `CHK("options", 6'h3f, opt)
        `CHK("wdog", 1'b1, wsus)
        @(posedge sys_clk);
        pup <= 1'b1;
        @(posedge sys_clk);
        pup <= 1'b0;
        tick(2);
        `CHK("key lock", 6'h2f, opt)
        u_host.wr(imp_pkg::ADDR_SYS_OPTIONS, 8'h00);
        tick(2);
        `CHK("options clear", 6'h00, opt)
    endtask
    // verdict and end of run
    task automatic conclude();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_masks();
        t_domain();
        t_options();
        conclude();
    end
    // hang guard
    initial begin
        repeat (50000) @(posedge sys_clk);
        errors++;
        conclude();
    end
endmodule
